// File: flash_ctrl_pkg.sv
// constants, commands and operation codes for the nor flash host controller
// Overview of operation
// - id mode may be entered in program suspend; exiting returns there
// - chip erase: two unlocks, 80H, two unlocks, then 10H
// - hardware reset ends chip erase; host reissues the full sequence
// - erase done: polling bit one, toggle steady over two reads; chip erase completion is checked on the toggle only
// - sector erase: two unlocks, 80H, two unlocks, 30H at sector
// - each extra 30H load must start within 50us of previous write
package flash_ctrl_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 12;

  // times as printed and the cycle counts derived from them
  localparam int PSUSP_MAX_US = 15;
  localparam int ESUSP_MAX_US = 20;
  localparam int LOAD_WIN_US = 50;
  localparam int PSUSP_CYC = PSUSP_MAX_US * CLK_MHZ;
  localparam int ESUSP_CYC = ESUSP_MAX_US * CLK_MHZ;
  localparam int LOAD_WIN_CYC = LOAD_WIN_US * CLK_MHZ;
  // margin so the next load still begins well inside the window
  localparam int LOAD_GUARD_CYC = 50;
  // bus timing of this controller (plain defaults)
  localparam int WE_LOW_NS = 50;
  localparam int RD_ACC_NS = 100;
  localparam int RST_LOW_NS = 500;
  localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_ACC_CYC = (RD_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_LOW_CYC = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 2;

  // status bit positions on the data bus
  localparam int POS_POLL = 7;
  localparam int POS_TOGGLE = 6;
  localparam int POS_TIMER = 3;
  localparam int POS_ETOGGLE = 2;

  // unlock addresses and command codes
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h0002AA;
  localparam logic [DATA_W-1:0] CD_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CD_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CD_CHIP = 16'h0010;
  localparam logic [DATA_W-1:0] CD_SECTOR = 16'h0030;
  localparam logic [DATA_W-1:0] CD_SUSPEND = 16'h00B0;
  localparam logic [DATA_W-1:0] CD_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CD_ID = 16'h0090;
  localparam logic [DATA_W-1:0] CD_RESET = 16'h00F0;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_CHIP_ERASE = 4'h2,
    OP_SECTOR_ERASE = 4'h3,
    OP_ADD_SECTOR = 4'h4,
    OP_ERASE_SUSPEND = 4'h5,
    OP_ERASE_RESUME = 4'h6,
    OP_PROG_SUSPEND = 4'h7,
    OP_PROG_RESUME = 4'h8,
    OP_ID_ENTER = 4'h9,
    OP_ID_EXIT = 4'hA,
    OP_POLL = 4'hB,
    OP_HW_RESET = 4'hC
  } op_t;
endpackage

// File: flash_bus_cycle.sv
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_ctrl_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic start, // one-cycle request
  input wire logic is_read, // 1 read, 0 write
  input wire logic [ADDR_W-1:0] addr, // word address
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic [DATA_W-1:0] dq_in, // data pins, raw
  output logic [ADDR_W-1:0] addr_o, // address pins
  output logic [DATA_W-1:0] dq_out, // data pins out
  output logic dq_oe, // data pins driven
  output logic ce_n, // chip select
  output logic we_n, // write strobe
  output logic oe_n, // output enable
  output logic done, // one-cycle end pulse
  output logic [DATA_W-1:0] rdata // captured read data
);
  logic [DATA_W-1:0] sync1_r, sync2_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, rd_r, rd_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] dq_nxt, rdata_nxt;
  logic oe_nxt, ce_nxt, we_nxt, rdn_nxt, done_nxt;

  localparam logic [CNT_W-1:0] WR_LEN = CNT_W'(WE_LOW_CYC + 2);
  localparam logic [CNT_W-1:0] RD_LEN = CNT_W'(RD_ACC_CYC + SYNC_CYC + 1);

  // next values: address set up first, strobe low, strobe high, chip select released last
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    rd_nxt = rd_r;
    addr_nxt = addr_o;
    dq_nxt = dq_out;
    rdata_nxt = rdata;
    oe_nxt = dq_oe;
    ce_nxt = ce_n;
    we_nxt = we_n;
    rdn_nxt = oe_n;
    done_nxt = 1'b0;
    if (!busy_r) begin
      if (start) begin
        busy_nxt = 1'b1;
        rd_nxt = is_read;
        addr_nxt = addr;
        dq_nxt = wdata;
        oe_nxt = !is_read;
        ce_nxt = 1'b0;
        cnt_nxt = '0;
      end
    end else begin
      cnt_nxt = cnt_r + 1'b1;
      if (rd_r) begin
        rdn_nxt = 1'b0;
        if (cnt_r == RD_LEN) begin
          rdata_nxt = sync2_r;
          rdn_nxt = 1'b1;
          ce_nxt = 1'b1;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end else begin
        // address latched at strobe fall, data at rise
        we_nxt = (cnt_r >= WR_LEN - 1'b1);
        if (cnt_r == 0) begin
          we_nxt = 1'b1;
        end
        if (cnt_r == WR_LEN) begin
          ce_nxt = 1'b1;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
    end
    if (!busy_nxt && !done_nxt) begin
      oe_nxt = dq_oe & busy_r;
    end
    if (done_nxt) begin
      oe_nxt = 1'b0;
    end
  end

  // registers; the pin data passes two flops before capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      rd_r <= 1'b0;
      addr_o <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      sync1_r <= dq_in;
      sync2_r <= sync1_r;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      rd_r <= rd_nxt;
      addr_o <= addr_nxt;
      dq_out <= dq_nxt;
      dq_oe <= oe_nxt;
      ce_n <= ce_nxt;
      we_n <= we_nxt;
      oe_n <= rdn_nxt;
      done <= done_nxt;
      rdata <= rdata_nxt;
    end
  end
endmodule

// File: flash_erase_program_suspend_ctrl.sv
// host-side sequencer for erase, program, suspend and resume on nor flash
`timescale 1ns/1ps
module flash_erase_program_suspend_ctrl
  import flash_ctrl_pkg::*;
(
  input wire logic clk_sys, // system clock 25 MHz
  input wire logic rst_n, // sync reset, active low
  input wire logic cmd_valid, // user request
  input wire logic [3:0] cmd_op, // operation code
  input wire logic [ADDR_W-1:0] cmd_addr, // word or sector address
  input wire logic [DATA_W-1:0] cmd_wdata, // program data
  output logic cmd_ready, // ready for a request
  output logic cmd_done, // one-cycle completion
  output logic cmd_refused, // one-cycle refusal
  output logic [DATA_W-1:0] rd_data, // last data read
  output logic data_polling_bit, // last polled bit 7
  output logic toggle_status_bit, // last polled bit 6
  output logic erase_toggle_bit, // last polled bit 2
  output logic erase_timer_flag, // last polled bit 3
  output logic ready_busy_sync, // ready/busy pin, synced
  output logic load_window_open, // extra sector load allowed
  output logic erase_suspended, // erase suspend in force
  output logic prog_suspended, // program suspend in force
  output logic id_mode, // id code mode in force
  output logic [ADDR_W-1:0] flash_addr, // address pins
  output logic [DATA_W-1:0] flash_dq_out, // data pins out
  output logic flash_dq_oe, // data pins driven
  input wire logic [DATA_W-1:0] flash_dq_in, // data pins in
  output logic flash_ce_n, // chip select
  output logic flash_we_n, // write strobe
  output logic flash_oe_n, // output enable
  output logic flash_reset_n, // hardware reset pin
  input wire logic ready_busy_n // ready/busy pin
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_SEQ = 7'b0000010,
    ST_SEQ_W = 7'b0000100,
    ST_RD = 7'b0001000,
    ST_RD_W = 7'b0010000,
    ST_HOLD = 7'b0100000,
    ST_RST = 7'b1000000
  } state_t;

  // length of the write sequence of an operation
  function automatic logic [2:0] seq_len(input op_t op);
    case (op)
      OP_PROGRAM: seq_len = 3'd4;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: seq_len = 3'd6;
      OP_ID_ENTER: seq_len = 3'd3;
      default: seq_len = 3'd1;
    endcase
  endfunction

  // address and data of write number idx of an operation
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_t op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] last;
    last = CD_RESET;
    case (op)
      OP_CHIP_ERASE: last = CD_CHIP;
      OP_SECTOR_ERASE, OP_ADD_SECTOR: last = CD_SECTOR;
      OP_ERASE_SUSPEND, OP_PROG_SUSPEND: last = CD_SUSPEND;
      OP_ERASE_RESUME, OP_PROG_RESUME: last = CD_RESUME;
      OP_PROGRAM: last = CD_PROGRAM;
      OP_ID_ENTER: last = CD_ID;
      default: last = CD_RESET;
    endcase
    case (idx)
      3'd0, 3'd3: seq_word = {UNLOCK_A1, CD_UNLOCK1};
      3'd1, 3'd4: seq_word = {UNLOCK_A2, CD_UNLOCK2};
      3'd2: seq_word = {UNLOCK_A1, (op == OP_PROGRAM || op == OP_ID_ENTER) ?
          last : CD_SETUP};
      default: seq_word = {a, last};
    endcase
    // program data cycle, and sector address on the sixth write
    if (op == OP_PROGRAM && idx == 3'd3) begin
      seq_word = {a, d};
    end
    if (seq_len(op) == 3'd1) begin
      // suspend address is ignored by the device
      seq_word = {(op == OP_ADD_SECTOR) ? a : '0, last};
    end
  endfunction

  state_t st_r, st_nxt;
  op_t op_r, op_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt, rd_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, win_r, win_nxt;
  logic poll_r, poll_nxt, prev_r, prev_nxt, have_r, have_nxt;
  logic prog_run_r, prog_run_nxt, chip_run_r, chip_run_nxt;
  logic erase_run_r, erase_run_nxt, loading_r, loading_nxt;
  logic esusp_nxt, psusp_nxt, id_nxt, rdy_nxt, done_nxt, ref_nxt, rstp_nxt;
  logic poll_b_nxt, tog_nxt, etog_nxt, tim_nxt, win_open_nxt;
  logic rb1_r, rb2_r;
  logic bus_start, bus_read, bus_done;
  logic [ADDR_W+DATA_W-1:0] word;
  logic [DATA_W-1:0] bus_rdata;
  logic legal;
  op_t req;

  // sequence 'legal' decides which requests the device may see now
  always_comb begin
    req = op_t'(cmd_op);
    legal = 1'b0;
    case (req)
      OP_READ, OP_POLL, OP_HW_RESET: legal = 1'b1;
      // no writes while an erase algorithm runs
      OP_PROGRAM: legal = !chip_run_r && !prog_run_r && !loading_r &&
          (!erase_run_r || erase_suspended);
      OP_CHIP_ERASE, OP_SECTOR_ERASE: legal = !chip_run_r && !prog_run_r
          && !erase_run_r && !id_mode;
      // extra load only while window open with margin
      OP_ADD_SECTOR: legal = load_window_open;
      OP_ERASE_SUSPEND: legal = erase_run_r && !erase_suspended;
      OP_ERASE_RESUME: legal = erase_suspended && !prog_run_r;
      OP_PROG_SUSPEND: legal = prog_run_r && !prog_suspended;
      OP_PROG_RESUME: legal = prog_suspended && !id_mode;
      // id mode from read, program suspend or erase suspend
      OP_ID_ENTER: legal = !id_mode && !chip_run_r && !loading_r &&
          (!prog_run_r || prog_suspended) &&
          (!erase_run_r || erase_suspended);
      OP_ID_EXIT: legal = id_mode;
      default: legal = 1'b0;
    endcase
  end

  // main sequencer next-state logic
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    poll_nxt = poll_r;
    prev_nxt = prev_r;
    have_nxt = have_r;
    prog_run_nxt = prog_run_r;
    chip_run_nxt = chip_run_r;
    erase_run_nxt = erase_run_r;
    loading_nxt = loading_r;
    esusp_nxt = erase_suspended;
    psusp_nxt = prog_suspended;
    id_nxt = id_mode;
    rdy_nxt = cmd_ready;
    rd_nxt = rd_data;
    poll_b_nxt = data_polling_bit;
    tog_nxt = toggle_status_bit;
    etog_nxt = erase_toggle_bit;
    tim_nxt = erase_timer_flag;
    rstp_nxt = 1'b1;
    done_nxt = 1'b0;
    ref_nxt = 1'b0;
    bus_start = 1'b0;
    bus_read = 1'b0;
    word = seq_word(op_r, idx_r, addr_r, wdata_r);
    // load window counts from the end of the last 30H write
    win_nxt = win_r;
    if (loading_r) begin
      if (win_r >= CNT_W'(LOAD_WIN_CYC)) begin
        loading_nxt = 1'b0; // window closed, erase runs
      end else begin
        win_nxt = win_r + 1'b1;
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          op_nxt = req;
          addr_nxt = cmd_addr;
          wdata_nxt = cmd_wdata;
          idx_nxt = '0;
          if (!legal) begin
            ref_nxt = 1'b1;
          end else begin
            rdy_nxt = 1'b0;
            poll_nxt = (req == OP_POLL);
            have_nxt = 1'b0;
            cnt_nxt = '0;
            if (req == OP_READ || req == OP_POLL) begin
              st_nxt = ST_RD;
            end else if (req == OP_HW_RESET) begin
              st_nxt = ST_RST;
            end else begin
              st_nxt = ST_SEQ;
            end
          end
        end
      end
      ST_SEQ: begin
        bus_start = 1'b1;
        st_nxt = ST_SEQ_W;
      end
      ST_SEQ_W: begin
        if (bus_done) begin
          if (idx_r != seq_len(op_r) - 3'd1) begin
            idx_nxt = idx_r + 3'd1;
            st_nxt = ST_SEQ;
          end else begin
            st_nxt = ST_IDLE;
            rdy_nxt = 1'b1;
            done_nxt = 1'b1;
            case (op_r)
              OP_PROGRAM: prog_run_nxt = 1'b1;
              // device pre-programs by itself; nothing more to send
              OP_CHIP_ERASE: chip_run_nxt = 1'b1;
              OP_SECTOR_ERASE, OP_ADD_SECTOR: begin
                erase_run_nxt = 1'b1;
                loading_nxt = 1'b1;
                win_nxt = '0;
              end
              OP_ERASE_SUSPEND: begin
                esusp_nxt = 1'b1;
                loading_nxt = 1'b0;
                // inside the window suspend is immediate
                if (!loading_r) begin
                  st_nxt = ST_HOLD;
                  cnt_nxt = CNT_W'(ESUSP_CYC);
                  rdy_nxt = 1'b0;
                  done_nxt = 1'b0;
                end
              end
              OP_PROG_SUSPEND: begin
                psusp_nxt = 1'b1;
                st_nxt = ST_HOLD;
                cnt_nxt = CNT_W'(PSUSP_CYC);
                rdy_nxt = 1'b0;
                done_nxt = 1'b0;
              end
              OP_PROG_RESUME: psusp_nxt = 1'b0;
              OP_ERASE_RESUME: esusp_nxt = 1'b0;
              OP_ID_ENTER: id_nxt = 1'b1;
              // exit falls back to any suspend still held
              OP_ID_EXIT: id_nxt = 1'b0;
              default: id_nxt = id_mode;
            endcase
          end
        end
      end
      ST_RD: begin
        bus_start = 1'b1;
        bus_read = 1'b1;
        word = {addr_r, wdata_r};
        st_nxt = ST_RD_W;
      end
      ST_RD_W: begin
        if (bus_done) begin
          // id codes sit at low addresses in id mode
          rd_nxt = bus_rdata;
          // progress bits captured on every read
          poll_b_nxt = bus_rdata[POS_POLL];
          tog_nxt = bus_rdata[POS_TOGGLE];
          etog_nxt = bus_rdata[POS_ETOGGLE];
          tim_nxt = bus_rdata[POS_TIMER];
          prev_nxt = bus_rdata[POS_TOGGLE];
          have_nxt = 1'b1;
          st_nxt = ST_IDLE;
          rdy_nxt = 1'b1;
          done_nxt = 1'b1;
          // finished only when toggle is steady over two reads
          if (poll_r && !(have_r && prev_r == bus_rdata[POS_TOGGLE] &&
              (!erase_run_r || prog_run_r || bus_rdata[POS_POLL]))) begin
            st_nxt = ST_RD;
            rdy_nxt = 1'b0;
            done_nxt = 1'b0;
          end else if (poll_r) begin
            // program in erase suspend ends first
            if (prog_run_r) begin
              if (!prog_suspended) begin
                prog_run_nxt = 1'b0;
              end
            end else if (!erase_suspended && !loading_r) begin
              // device back in array read
              chip_run_nxt = 1'b0;
              erase_run_nxt = 1'b0;
            end
          end
        end
      end
      ST_HOLD: begin
        // wait out the longest suspend time before reading other sectors
        if (cnt_r == '0) begin
          st_nxt = ST_IDLE;
          rdy_nxt = 1'b1;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_RST: begin
        // hardware reset ends any erase; user must reissue
        rstp_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(RST_LOW_CYC)) begin
          rstp_nxt = 1'b1;
          prog_run_nxt = 1'b0;
          chip_run_nxt = 1'b0;
          erase_run_nxt = 1'b0;
          loading_nxt = 1'b0;
          esusp_nxt = 1'b0;
          psusp_nxt = 1'b0;
          id_nxt = 1'b0;
          st_nxt = ST_IDLE;
          rdy_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    win_open_nxt = loading_nxt &&
        (win_nxt < CNT_W'(LOAD_WIN_CYC - LOAD_GUARD_CYC));
  end

  // registers of the sequencer; ready/busy pin is synchronised first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      op_r <= OP_READ;
      addr_r <= '0;
      wdata_r <= '0;
      idx_r <= '0;
      cnt_r <= '0;
      win_r <= '0;
      poll_r <= 1'b0;
      prev_r <= 1'b0;
      have_r <= 1'b0;
      prog_run_r <= 1'b0;
      chip_run_r <= 1'b0;
      erase_run_r <= 1'b0;
      loading_r <= 1'b0;
      erase_suspended <= 1'b0;
      prog_suspended <= 1'b0;
      id_mode <= 1'b0;
      cmd_ready <= 1'b1;
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
      rd_data <= '0;
      data_polling_bit <= 1'b0;
      toggle_status_bit <= 1'b0;
      erase_toggle_bit <= 1'b0;
      erase_timer_flag <= 1'b0;
      load_window_open <= 1'b0;
      flash_reset_n <= 1'b1;
      rb1_r <= 1'b1;
      rb2_r <= 1'b1;
      ready_busy_sync <= 1'b1;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      poll_r <= poll_nxt;
      prev_r <= prev_nxt;
      have_r <= have_nxt;
      prog_run_r <= prog_run_nxt;
      chip_run_r <= chip_run_nxt;
      erase_run_r <= erase_run_nxt;
      loading_r <= loading_nxt;
      erase_suspended <= esusp_nxt;
      prog_suspended <= psusp_nxt;
      id_mode <= id_nxt;
      cmd_ready <= rdy_nxt;
      cmd_done <= done_nxt;
      cmd_refused <= ref_nxt;
      rd_data <= rd_nxt;
      data_polling_bit <= poll_b_nxt;
      toggle_status_bit <= tog_nxt;
      erase_toggle_bit <= etog_nxt;
      erase_timer_flag <= tim_nxt;
      load_window_open <= win_open_nxt;
      flash_reset_n <= rstp_nxt;
      rb1_r <= ready_busy_n;
      rb2_r <= rb1_r;
      ready_busy_sync <= rb2_r;
    end
  end

  // pin-level cycle engine
  flash_bus_cycle u_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(bus_start),
    .is_read(bus_read),
    .addr(word[ADDR_W+DATA_W-1:DATA_W]),
    .wdata(word[DATA_W-1:0]),
    .dq_in(flash_dq_in),
    .addr_o(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_n(flash_oe_n),
    .done(bus_done),
    .rdata(bus_rdata)
  );
endmodule

// File: flash_dev_model.sv
// behavioural nor flash device facing the controller's pins
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h005A // arbitrary value
) (
  input wire logic tick, // time base
  input wire logic [22:0] addr, // address pins
  input wire logic [15:0] dq_out, // data from host
  input wire logic dq_oe, // host drives data
  input wire logic ce_n, // chip select
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output enable
  input wire logic reset_n, // hardware reset
  output logic [15:0] dq_in, // data to host
  output logic ready_busy_n // low while busy
);
  localparam int PR_CYC = 100;
  localparam int ER_CYC = 300;
  localparam int WIN_CYC = 1250; // 50us at 25 MHz
  logic [47:0] hist;
  logic er, pr, esus, psus, idm, tog, we_q, oe_q;
  logic [15:0] val;
  int prem, erem, win;
  wire [7:0] d = dq_out[7:0];
  wire run = win > 0 || (pr && !psus) || (er && !esus);
  initial {er, pr, esus, psus, idm, tog, hist} = '0;
  // status word while busy, id codes in id mode, else erased array
  always_comb begin
    if (run)
      val = {9'h000, tog, 2'b00, win == 0, tog, 2'b00};
    else if (idm)
      val = addr[1:0] == 2'h0 ? MAKER_ID : addr[1:0] == 2'h1 ? PART_ID : 16'h0;
    else
      val = 16'hFFFF;
  end
  // released bus shows the inverse so stale data never looks valid
  assign dq_in = (!ce_n && !oe_n && !dq_oe) ? val : ~val;
  assign ready_busy_n = !run;
  // commands taken as the strobe rises, the earlier of the two edges
  always @(posedge tick) begin
    if (!reset_n) begin
      {er, pr, esus, psus, idm, tog, hist} = '0;
      win = 0;
    end else begin
      if (oe_q && !oe_n && run) tog = !tog;
      if (win > 0) begin
        win--;
        if (win == 0) erem = ER_CYC;
      end else if (pr && !psus) begin
        prem--;
        pr = prem > 0;
      end else if (er && !esus) begin
        erem--;
        er = erem > 0;
      end
      if (!we_q && we_n && !ce_n) begin
        hist = {hist[39:0], d};
        if (win > 0) begin
          if (d == 8'h30) win = WIN_CYC;
          else if (d == 8'hB0) begin
            win = 0;
            erem = ER_CYC;
            esus = 1;
          end else begin
            win = 0;
            er = 0;
          end
        end else if (pr && !psus) begin
          if (d == 8'hB0) psus = 1;
        end else if (er && !esus) begin
          if (d == 8'hB0) esus = 1;
        end else if (idm) begin
          if (d == 8'hF0) idm = 0;
        end else if (psus && d == 8'h30) psus = 0;
        else if (esus && !pr && d == 8'h30) esus = 0;
        else if (hist == 48'hAA5580AA5510 && !esus) begin
          er = 1;
          erem = ER_CYC;
        end else if (hist == 48'hAA5580AA5530 && !esus) begin
          er = 1;
          win = WIN_CYC;
        end else if (hist[31:8] == 24'hAA55A0 && !pr) begin
          pr = 1;
          prem = PR_CYC;
        end else if (hist[23:0] == 24'hAA5590) idm = 1;
      end
    end
    we_q = we_n;
    oe_q = oe_n;
  end
endmodule

// File: flash_ctrl_chk.sv
// port assertions for the flash erase and suspend controller
`timescale 1ns/1ps
module flash_ctrl_chk
  import flash_ctrl_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic cmd_valid, // request
  input wire logic [3:0] cmd_op, // op code
  input wire logic cmd_ready, // idle
  input wire logic cmd_refused, // refusal
  input wire logic load_window_open, // load window
  input wire logic erase_suspended, // suspended
  input wire logic flash_ce_n, // select
  input wire logic flash_we_n, // strobe
  input wire logic flash_oe_n, // read enable
  input wire logic flash_reset_n // reset pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire take = cmd_valid && cmd_ready;
  a_accept_busy: assert property (
    take |=> ##[0:1] (!cmd_ready || cmd_refused)) else $error("no accept");
  a_refuse_pulse: assert property (
    cmd_refused |=> !cmd_refused) else $error("refusal too long");
  a_write_select: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n) else $error("bad write");
  a_read_select: assert property (
    !flash_oe_n |-> !flash_ce_n && flash_we_n) else $error("bad read");
  a_we_width: assert property (
    $fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n) else $error("we width");
  a_reset_hold: assert property (
    $fell(flash_reset_n) |=> !flash_reset_n [*8]) else $error("short reset");
  a_add_closed: assert property (
    take && cmd_op == OP_ADD_SECTOR && !load_window_open
    |=> ##[0:1] cmd_refused) else $error("add outside window");
  a_resume_idle: assert property (
    take && cmd_op == OP_ERASE_RESUME && !erase_suspended
    |=> ##[0:1] cmd_refused) else $error("resume not suspended");
endmodule
bind flash_erase_program_suspend_ctrl flash_ctrl_chk u_flash_ctrl_chk (.*);

// File: tb.sv
// self-checking bench for the flash erase and suspend controller
`timescale 1ns/1ps
module tb
  import flash_ctrl_pkg::*;
;
  localparam logic [15:0] MAKER_ID = 16'h00A5; // arbitrary value
  localparam logic [15:0] PART_ID = 16'h005A; // arbitrary value
  logic clk_sys, rst_n, cmd_valid, cmd_ready, cmd_done, cmd_refused;
  logic [3:0] cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr;
  logic [DATA_W-1:0] cmd_wdata, rd_data, flash_dq_out, flash_dq_in;
  logic data_polling_bit, toggle_status_bit, erase_toggle_bit;
  logic erase_timer_flag, ready_busy_sync, load_window_open;
  logic erase_suspended, prog_suspended, id_mode, flash_dq_oe, flash_ce_n;
  logic flash_we_n, flash_oe_n, flash_reset_n, ready_busy_n;
  int miscompares, compares, cycles;
  flash_erase_program_suspend_ctrl u_flash_erase_program_suspend_ctrl (.*);
  flash_dev_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_flash_dev_model (
    .tick(clk_sys), .addr(flash_addr), .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe), .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .reset_n(flash_reset_n), .dq_in(flash_dq_in),
    .ready_busy_n(ready_busy_n));
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = !clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one request, then done or refusal as expected within a bound
  task automatic op(input op_t o, input logic [22:0] a, input logic r);
    @(posedge clk_sys);
    cmd_valid <= 1;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_wdata <= a[15:0];
    @(posedge clk_sys);
    cmd_valid <= 0;
    for (int n = 0; n < 3000 && cmd_done !== 1 && cmd_refused !== 1; n++)
      @(posedge clk_sys);
    chk({cmd_done, cmd_refused}, {!r, r});
  endtask
  task automatic t_chip;
    op(OP_ADD_SECTOR, 0, 1);
    op(OP_ERASE_RESUME, 0, 1);
    op(OP_CHIP_ERASE, 0, 0);
    op(OP_PROGRAM, 23'h000040, 1);
    chk(ready_busy_sync, 0);
    op(OP_ERASE_SUSPEND, 0, 1);
    op(OP_POLL, 0, 0);
    chk(data_polling_bit, 1);
    op(OP_CHIP_ERASE, 0, 0);
    op(OP_HW_RESET, 0, 0);
    chk(ready_busy_sync, 1);
  endtask
  task automatic t_prog;
    op(OP_PROGRAM, 23'h000100, 0);
    op(OP_PROG_SUSPEND, 0, 0);
    chk(prog_suspended, 1);
    op(OP_ID_ENTER, 0, 0);
    op(OP_READ, 0, 0);
    chk(rd_data, MAKER_ID);
    op(OP_READ, 1, 0);
    chk(rd_data, PART_ID);
    op(OP_ID_EXIT, 0, 0);
    chk(prog_suspended, 1);
    op(OP_READ, 23'h200000, 0);
    chk(rd_data, 16'hFFFF);
    op(OP_PROG_RESUME, 0, 0);
    op(OP_POLL, 0, 0);
    chk(ready_busy_sync, 1);
  endtask
  task automatic t_sector;
    op(OP_SECTOR_ERASE, 23'h010000, 0);
    chk(load_window_open, 1);
    op(OP_ADD_SECTOR, 23'h020000, 0);
    op(OP_PROGRAM, 23'h300000, 1);
    op(OP_ERASE_SUSPEND, 0, 0);
    chk({erase_suspended, load_window_open}, 2'b10);
    op(OP_PROGRAM, 23'h300000, 0);
    op(OP_POLL, 0, 0);
    op(OP_ERASE_RESUME, 0, 0);
    chk(erase_suspended, 0);
    op(OP_POLL, 0, 0);
    chk({data_polling_bit, erase_timer_flag}, 2'b11);
  endtask
  task automatic conclude;
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    {rst_n, cmd_valid, cmd_op, cmd_addr, cmd_wdata} = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    t_chip;
    t_prog;
    t_sector;
    conclude;
  end
endmodule
